// *** src/qcp_consts.svh ***
// constants for the quad counter, pwm and capture block
// assumes a 32-bit classic wishbone slave with byte addresses, register index in bits 4:2
// Behaviour
// - direction bit per counter: set up, clear down
// - cascade bits join A+B and C+D as 16-bit
// - cascaded B and D follow A and C direction
// - upcount hits target, next tick interrupts, reloads zero
// - downcount hits zero, next tick interrupts, reloads value
// - restart at terminal count may interrupt again
// - pwm bits drive port B pin 0 or 1
// - pwm counters follow direction, raise no interrupts
// - pwm counters wrap at zero and maximum
// - internal pwm high while counter not above code
// - pin pwm is sampled once per counter clock
// - resolution 8 single, 10 to 16 cascaded
// - code above cascaded maximum holds output high
// - period two to resolution, high code plus one
// - capture reads shadows, each update interrupts
// - second config bits 5:4 select capture edge
// - bits 7:6 select pin 2, pin 3, 16k, 1k
// - capture works with pwm, counters wrap circularly
// - capture interrupt one or two counter clocks late
// - capture pulse phases must exceed a counter period
// - timer value write clears or loads the counter unless it runs pwm or capture
`ifndef QCP_CONSTS_SVH
`define QCP_CONSTS_SVH
`define ADR_CFG_FIRST  3'h0
`define ADR_CFG_SECOND 3'h1
`define ADR_VAL_A      3'h2
`define ADR_RUN        3'h6
`define ADR_PORT_B     3'h7
`define BIT_PWM_AB     0
`define BIT_CASC_AB    2
`define BIT_DIR_A      4
`define BIT_CAP_EDGE   4
`define BIT_CAP_SRC    6
`define RST_BYTE       8'h00
`define RST_RUN        4'h0
`define MAX_8          16'h00FF
`define MAX_10         16'h03FF
`define MAX_12         16'h0FFF
`define MAX_14         16'h3FFF
`define MAX_16         16'hFFFF
`endif

// *** src/qcp_pkg.sv ***
// types shared by the quad counter block
// assumes qcp_consts.svh for register constants; the enum codes below are literal values
package qcp_pkg;
    typedef enum logic [1:0] {
        CAP_OFF  = 2'h0,
        CAP_RISE = 2'h1,
        CAP_FALL = 2'h2,
        CAP_BOTH = 2'h3
    } capEdge_t;
    typedef enum logic [1:0] {
        SRC_PIN2 = 2'h0,
        SRC_PIN3 = 2'h1,
        SRC_16K  = 2'h2,
        SRC_1K   = 2'h3
    } capSrc_t;
    typedef logic [7:0] byte_t;
endpackage

// *** src/quad_counter_pwm_capture.sv ***
// four 8-bit counters with cascade, pwm and a capture block
// assumes counter clocks arrive as one-cycle enables on clk
`timescale 1ns/1ns
`default_nettype none
`include "qcp_consts.svh"
module quad_counter_pwm_capture
    import qcp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic      [31:0] wbDatO,
    output logic             wbAck,
    input  wire logic [3:0]  cntTick,
    input  wire logic [3:2]  portAPins,
    input  wire logic        prescaler1k,
    input  wire logic        prescaler16k,
    output logic      [1:0]  portBPins,
    output logic      [3:0]  cntIrq
);
    byte_t       cfgFirst_q, cfgFirst_d;
    byte_t       cfgSecond_q, cfgSecond_d;
    byte_t       val_q [4];
    byte_t       val_d [4];
    logic [3:0]  runEn_q, runEn_d;
    byte_t       portBReg_q, portBReg_d;
    logic        ack_q, ack_d;
    logic [31:0] datO_q, datO_d;
    logic [1:0]  portB_q, portB_d;
    logic [3:0]  irq_q, irq_d;
    wire  byte_t cntAll [4];
    wire  logic [3:0] irqTimer;
    wire  logic [1:0] pwmOut;
    logic [3:0]  valWr;
    logic        wrEn;
    logic        req;
    capEdge_t    capEdge;
    capSrc_t     capSrc;
    logic        capOn;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    assign capEdge = capEdge_t'(cfgSecond_q[`BIT_CAP_EDGE +: 2]);
    assign capSrc  = capSrc_t'(cfgSecond_q[`BIT_CAP_SRC +: 2]);
    assign capOn   = capEdge != CAP_OFF;
    assign req     = wbCyc & wbStb;
    // writes land on the edge where the master sees ack
    assign wrEn    = req & wbWe & ack_q & wbSel[0];

    function automatic logic [15:0] resMax(input logic [1:0] res);
        unique case (res)
            2'h0: return `MAX_10;
            2'h1: return `MAX_12;
            2'h2: return `MAX_14;
            2'h3: return `MAX_16;
        endcase
    endfunction

    // returns {terminal interrupt, next count}
    function automatic logic [16:0] stepCnt(
        input logic [15:0] v,
        input logic [15:0] c,
        input logic [15:0] m,
        input logic        up,
        input logic        circ
    );
        logic        t;
        logic [15:0] n;
        t = up ? (v == c) : (v == 16'h0000);
        if (circ)
            n = up ? ((v == m) ? 16'h0000 : v + 16'h0001)
                   : ((v == 16'h0000) ? m : v - 16'h0001);
        else
            n = up ? (t ? 16'h0000 : v + 16'h0001)
                   : (t ? c : v - 16'h0001);
        return {t & ~circ, n};
    endfunction

    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : gPair
            localparam int LO = 2 * p;
            localparam int HI = 2 * p + 1;
            byte_t       lo_q, lo_d, hi_q, hi_d;
            logic        pwm_q, pwm_d;
            logic [1:0]  tirq;
            logic        casc, pwmOn, capP;
            logic [15:0] m;
            logic [16:0] s16, sLo, sHi;
            logic        circLo, circHi, upLo, upHi;
            assign casc  = cfgFirst_q[`BIT_CASC_AB + p];
            assign pwmOn = cfgFirst_q[`BIT_PWM_AB + p];
            assign capP  = (p == 0) && capOn;
            assign upLo  = cfgFirst_q[`BIT_DIR_A + LO];
            // a cascaded upper byte takes the lower direction
            assign upHi  = casc ? upLo
                                : cfgFirst_q[`BIT_DIR_A + HI];
            assign m = pwmOn ? resMax(cfgSecond_q[2 * p +: 2])
                             : `MAX_16;
            assign circLo = pwmOn | capP;
            assign circHi = casc ? circLo : capP;
            assign s16 = stepCnt({hi_q, lo_q}, {val_q[HI], val_q[LO]},
                                 m, upLo, circLo);
            assign sLo = stepCnt({8'h00, lo_q}, {8'h00, val_q[LO]},
                                 `MAX_8, upLo, circLo);
            assign sHi = stepCnt({8'h00, hi_q}, {8'h00, val_q[HI]},
                                 `MAX_8, upHi, circHi);
            always_comb
            begin
                lo_d  = lo_q;
                hi_d  = hi_q;
                pwm_d = pwm_q;
                tirq  = 2'h0;
                if (casc)
                begin
                    // the upper run bit gates a cascaded pair
                    if (cntTick[LO] && runEn_q[HI])
                    begin
                        {hi_d, lo_d} = s16[15:0];
                        tirq[0] = s16[16];
                        pwm_d = {hi_q, lo_q}
                                <= {val_q[HI], val_q[LO]};
                    end
                end
                else
                begin
                    if (cntTick[LO] && runEn_q[LO])
                    begin
                        lo_d = sLo[7:0];
                        tirq[0] = sLo[16];
                        pwm_d = lo_q <= val_q[LO];
                    end
                    if (cntTick[HI] && runEn_q[HI])
                    begin
                        hi_d = sHi[7:0];
                        tirq[1] = sHi[16];
                    end
                end
                // timer value write restarts that byte unless it runs pwm or capture
                if (valWr[LO] && !circLo)
                    lo_d = upLo ? `RST_BYTE : wbDatI[7:0];
                if (valWr[HI] && !circHi)
                    hi_d = upHi ? `RST_BYTE : wbDatI[7:0];
            end
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    lo_q  <= `RST_BYTE;
                    hi_q  <= `RST_BYTE;
                    pwm_q <= 1'b0;
                end
                else
                begin
                    lo_q  <= lo_d;
                    hi_q  <= hi_d;
                    pwm_q <= pwm_d;
                end
            end
            assign cntAll[LO]   = lo_q;
            assign cntAll[HI]   = hi_q;
            assign irqTimer[LO] = tirq[0];
            assign irqTimer[HI] = tirq[1];
            assign pwmOut[p]    = pwm_q;
        end
    endgenerate

    // capture: pins pass three flops, change taken when 2nd and 3rd agree
    logic [3:2] pinS1_q, pinS2_q, pinS3_q, pinLvl_q, pinLvl_d;
    logic [1:0] smp1_q, smp1_d, smp2_q, smp2_d, capEv;
    byte_t      shadow_q [2];
    byte_t      shadow_d [2];
    logic       capSig;
    always_comb
    begin
        for (int b = 2; b < 4; b++)
            pinLvl_d[b] = (pinS2_q[b] == pinS3_q[b]) ? pinS3_q[b]
                                                     : pinLvl_q[b];
        unique case (capSrc)
            SRC_PIN2: capSig = pinLvl_q[2];
            SRC_PIN3: capSig = pinLvl_q[3];
            SRC_16K:  capSig = prescaler16k;
            SRC_1K:   capSig = prescaler1k;
        endcase
        smp1_d = smp1_q;
        smp2_d = smp2_q;
        capEv  = 2'h0;
        for (int k = 0; k < 2; k++)
        begin
            shadow_d[k] = shadow_q[k];
            // sampling on the counter clock drops pulses shorter
            // than one counter period and adds one or two ticks
            if (cfgFirst_q[`BIT_CASC_AB] ? cntTick[0] : cntTick[k])
            begin
                smp1_d[k] = capSig;
                smp2_d[k] = smp1_q[k];
                unique case (capEdge)
                    CAP_OFF:  capEv[k] = 1'b0;
                    CAP_RISE: capEv[k] = smp1_q[k] & ~smp2_q[k];
                    CAP_FALL: capEv[k] = ~smp1_q[k] & smp2_q[k];
                    CAP_BOTH: capEv[k] = smp1_q[k] ^ smp2_q[k];
                endcase
            end
            if (capEv[k])
                shadow_d[k] = cntAll[k];
        end
    end
    always_ff @(posedge clk)
    begin
        pinS1_q <= portAPins;
        pinS2_q <= pinS1_q;
        pinS3_q <= pinS2_q;
        if (rst)
        begin
            pinLvl_q    <= 2'h0;
            smp1_q      <= 2'h0;
            smp2_q      <= 2'h0;
            shadow_q[0] <= `RST_BYTE;
            shadow_q[1] <= `RST_BYTE;
        end
        else
        begin
            pinLvl_q    <= pinLvl_d;
            smp1_q      <= smp1_d;
            smp2_q      <= smp2_d;
            shadow_q[0] <= shadow_d[0];
            shadow_q[1] <= shadow_d[1];
        end
    end

    // register slave, outputs and event pulses
    always_comb
    begin
        cfgFirst_d  = cfgFirst_q;
        cfgSecond_d = cfgSecond_q;
        runEn_d     = runEn_q;
        portBReg_d  = portBReg_q;
        ack_d       = req & ~ack_q;
        datO_d      = datO_q;
        valWr       = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            val_d[i] = val_q[i];
            if (wrEn && wbAdr[4:2] == `ADR_VAL_A + 3'(i))
            begin
                val_d[i] = wbDatI[7:0];
                valWr[i] = 1'b1;
            end
        end
        if (wrEn)
        begin
            unique case (wbAdr[4:2])
                `ADR_CFG_FIRST:  cfgFirst_d  = wbDatI[7:0];
                `ADR_CFG_SECOND: cfgSecond_d = wbDatI[7:0];
                `ADR_RUN:        runEn_d     = wbDatI[3:0];
                `ADR_PORT_B:     portBReg_d  = wbDatI[7:0];
                default:         ;
            endcase
        end
        if (req && !ack_q)
        begin
            datO_d = 32'h0000_0000;
            unique case (wbAdr[4:2])
                `ADR_CFG_FIRST:  datO_d[7:0] = cfgFirst_q;
                `ADR_CFG_SECOND: datO_d[7:0] = cfgSecond_q;
                `ADR_RUN:        datO_d[3:0] = runEn_q;
                `ADR_PORT_B:     datO_d[7:0] = portBReg_q;
                3'h2:            datO_d[7:0] = capOn ? shadow_q[0]
                                                     : cntAll[0];
                3'h3:            datO_d[7:0] = capOn ? shadow_q[1]
                                                     : cntAll[1];
                3'h4:            datO_d[7:0] = cntAll[2];
                3'h5:            datO_d[7:0] = cntAll[3];
            endcase
        end
        for (int q = 0; q < 2; q++)
            portB_d[q] = cfgFirst_q[`BIT_PWM_AB + q] ? pwmOut[q]
                                                      : portBReg_q[q];
        irq_d = irqTimer | {2'h0, capEv};
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfgFirst_q  <= `RST_BYTE;
            cfgSecond_q <= `RST_BYTE;
            runEn_q     <= `RST_RUN;
            portBReg_q  <= `RST_BYTE;
            ack_q       <= 1'b0;
            datO_q      <= 32'h0000_0000;
            portB_q     <= 2'h0;
            irq_q       <= 4'h0;
            for (int i = 0; i < 4; i++)
                val_q[i] <= `RST_BYTE;
        end
        else
        begin
            cfgFirst_q  <= cfgFirst_d;
            cfgSecond_q <= cfgSecond_d;
            runEn_q     <= runEn_d;
            portBReg_q  <= portBReg_d;
            ack_q       <= ack_d;
            datO_q      <= datO_d;
            portB_q     <= portB_d;
            irq_q       <= irq_d;
            for (int i = 0; i < 4; i++)
                val_q[i] <= val_d[i];
        end
    end
    assign wbDatO    = datO_q;
    assign wbAck     = ack_q;
    assign portBPins = portB_q;
    assign cntIrq    = irq_q;

    // checks
    logic soloA, tickA;
    assign soloA = !cfgFirst_q[2] && !cfgFirst_q[0] && !capOn;
    assign tickA = cntTick[0] && runEn_q[0];
    sequence sReq;
        req && !ack_q;
    endsequence
    sequence sAck;
        ack_q ##1 !ack_q;
    endsequence
    AST_BUS_ACK: assert property (sReq |=> sAck)
        else $error("ack not a single pulse after request");
    AST_UP_WRAP: assert property (
        !cfgFirst_q[2] && !capOn && cntTick[1] && runEn_q[1]
        && cfgFirst_q[5] && !valWr[1] && cntAll[1] == val_q[1]
        |=> cntAll[1] == 8'h00 && cntIrq[1])
        else $error("upcount terminal handling wrong");
    AST_DOWN_LOAD: assert property (
        soloA && tickA && !cfgFirst_q[4] && !valWr[0]
        && cntAll[0] == 8'h00 |=> cntAll[0] == $past(val_q[0]) && cntIrq[0])
        else $error("downcount reload wrong");
    AST_PWM_QUIET: assert property (
        cfgFirst_q[0] |-> !irqTimer[0] && !(cfgFirst_q[2] && irqTimer[1]))
        else $error("pwm counter raised interrupt");
    AST_PWM_WRAP: assert property (
        cfgFirst_q[0] && !cfgFirst_q[2] && tickA && cfgFirst_q[4]
        && cntAll[0] == 8'hFF |=> cntAll[0] == 8'h00)
        else $error("pwm wrap wrong");
    AST_PWM_PIN: assert property (
        cfgFirst_q[0] && !cfgFirst_q[2] && tickA
        && cntAll[0] <= val_q[0] && $stable(cfgFirst_q)
        |=> ##1 portBPins[0])
        else $error("pwm pin not delayed copy");
    AST_CASC_DIR: assert property (
        cfgFirst_q[2] && !cfgFirst_q[0] && !capOn && cntTick[0]
        && runEn_q[1] && !cfgFirst_q[4] && cfgFirst_q[5]
        && {cntAll[1], cntAll[0]} == 16'h0100 && valWr == 4'h0
        |=> cntAll[1] == 8'h00)
        else $error("cascaded upper byte ignored lower direction");
    AST_CAP_IRQ: assert property (
        capEv[0] |=> cntIrq[0] && shadow_q[0] == $past(cntAll[0]))
        else $error("capture update without interrupt");
    AST_CAP_OFF: assert property (
        !capOn |-> capEv == 2'h0)
        else $error("capture while disabled");
endmodule
`default_nettype wire

// *** verif/quad_counter_pwm_capture_bench.sv ***
// self-checking bench for the quad counter, pwm and capture block
// assumes one-cycle wishbone answers and counter ticks as clk enables
`timescale 1ns/1ns
`default_nettype none
`include "qcp_consts.svh"
module quad_counter_pwm_capture_bench
    import qcp_pkg::*;
;
    typedef struct packed
    {
        logic [2:0] idx;
        logic [7:0] dat;
        logic [7:0] exp;
        logic [1:0] pins;
    } row_t;
    logic        clk          = 1'b0;
    logic        rst          = 1'b1;
    logic        wbCyc        = 1'b0;
    logic        wbStb        = 1'b0;
    logic        wbWe         = 1'b0;
    logic [7:0]  wbAdr        = 8'h00;
    logic [3:0]  wbSel        = 4'hF;
    logic [31:0] wbDatI       = 32'h0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic [3:0]  cntTick      = 4'h0;
    logic [3:2]  portAPins    = 2'h0;
    logic        prescaler1k  = 1'b0;
    logic        prescaler16k = 1'b0;
    logic [1:0]  portBPins;
    logic [3:0]  cntIrq;
    logic [31:0] rd;
    logic [31:0] shadow;
    int          fails        = 0;
    int          checked      = 0;
    int          cycles       = 0;
    int          hi;
    int          irqCnt [4]   = '{0, 0, 0, 0};
    int          base [4];
    row_t        rows [10]    = '{
        '{`ADR_PORT_B, 8'h03, 8'h03, 2'h3},
        '{`ADR_PORT_B, 8'h02, 8'h02, 2'h2},
        '{`ADR_VAL_A, 8'h5A, 8'h5A, 2'h2},
        '{3'h3, 8'hC4, 8'hC4, 2'h2},
        '{`ADR_CFG_FIRST, 8'hF0, 8'hF0, 2'h2},
        '{`ADR_VAL_A, 8'h33, 8'h00, 2'h2},
        '{3'h5, 8'hFF, 8'h00, 2'h2},
        '{`ADR_CFG_SECOND, 8'h0F, 8'h0F, 2'h2},
        '{`ADR_RUN, 8'h00, 8'h00, 2'h2},
        '{`ADR_CFG_FIRST, 8'h00, 8'h00, 2'h2}};
    logic [1:0]  capRow [7]   = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
    logic [1:0]  capEdg [7]   = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2, 2'h0};

    quad_counter_pwm_capture i_dut (
        .clk          (clk),
        .rst          (rst),
        .wbCyc        (wbCyc),
        .wbStb        (wbStb),
        .wbWe         (wbWe),
        .wbAdr        (wbAdr),
        .wbSel        (wbSel),
        .wbDatI       (wbDatI),
        .wbDatO       (wbDatO),
        .wbAck        (wbAck),
        .cntTick      (cntTick),
        .portAPins    (portAPins),
        .prescaler1k  (prescaler1k),
        .prescaler16k (prescaler16k),
        .portBPins    (portBPins),
        .cntIrq       (cntIrq)
    );

    always #50 clk = ~clk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // whole run is near 2150 cycles, so this only cuts a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        for (int i = 0; i < 4; i++)
            if (cntIrq[i] === 1'b1)
                irqCnt[i] <= irqCnt[i] + 1;
        if (cycles == 40000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // holds the request until ack is sampled, read data taken there
    task automatic wb(logic we, logic [2:0] idx, logic [7:0] dat);
        @(posedge clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= {3'h0, idx, 2'h0};
        wbDatI <= {24'h0, dat};
        do
            @(posedge clk);
        while (wbAck !== 1'b1);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask

    // returns two edges after the pin register has moved
    task automatic tick(logic [3:0] mask, int n);
        repeat (n)
        begin
            @(posedge clk);
            cntTick <= mask;
            @(posedge clk);
            cntTick <= 4'h0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic doReset(string name);
        $display("test %s done, mismatches %0d", name, fails);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        base = irqCnt;
    endtask

    // bit order: pin 2, pin 3, 16k, 1k, matching the source codes
    task automatic drive(logic [3:0] lv);
        @(posedge clk);
        {prescaler1k, prescaler16k, portAPins[3], portAPins[2]} <= lv;
        tick(4'h1, 3);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            wb(1'b1, rows[i].idx, rows[i].dat);
            wb(1'b0, rows[i].idx, 8'h00);
            check("register", rd, {24'h0, rows[i].exp});
            check("port b", portBPins, rows[i].pins);
        end
        wb(1'b1, `ADR_PORT_B, 8'h03);
        doReset("table");
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b0, i[2:0], 8'h00);
            check("reset value", rd, 32'h0);
        end
        check("reset pins", portBPins, 2'h0);
        // A counts down from 3, B counts up to target 2
        wb(1'b1, `ADR_CFG_FIRST, 8'h20);
        wb(1'b1, `ADR_VAL_A, 8'h03);
        wb(1'b1, 3'h3, 8'h02);
        wb(1'b1, `ADR_RUN, 8'h03);
        tick(4'h3, 3);
        check("down irq early", irqCnt[0] - base[0], 0);
        check("up irq", irqCnt[1] - base[1], 1);
        tick(4'h3, 1);
        check("down irq", irqCnt[0] - base[0], 1);
        wb(1'b0, `ADR_VAL_A, 8'h00);
        check("down reload", rd, 32'h3);
        wb(1'b0, 3'h3, 8'h00);
        check("up restart", rd, 32'h1);
        doReset("timer");
        // B direction bit set but A rules the pair: borrow crosses
        wb(1'b1, `ADR_CFG_FIRST, 8'h24);
        wb(1'b1, `ADR_VAL_A, 8'h01);
        wb(1'b1, 3'h3, 8'h01);
        wb(1'b1, `ADR_RUN, 8'h02);
        tick(4'h3, 2);
        wb(1'b0, `ADR_VAL_A, 8'h00);
        check("cascade low", rd, 32'hFF);
        wb(1'b0, 3'h3, 8'h00);
        check("cascade high", rd, 32'h0);
        doReset("cascade");
        wb(1'b1, `ADR_CFG_FIRST, 8'h11);
        wb(1'b1, `ADR_VAL_A, 8'h01);
        wb(1'b1, `ADR_RUN, 8'h01);
        tick(4'h1, 2);
        hi = 0;
        repeat (256)
        begin
            tick(4'h1, 1);
            hi += portBPins[0];
        end
        check("pwm high count", hi, 2);
        check("pwm irq", irqCnt[0] - base[0], 0);
        wb(1'b0, `ADR_VAL_A, 8'h00);
        check("pwm wrap", rd, 32'h2);
        // down from zero wraps to 0x3FF below code 0x400 at 10 bits, far above it at 16
        for (int r = 0; r < 4; r += 3)
        begin
            doReset("pwm");
            wb(1'b1, `ADR_CFG_FIRST, 8'h05);
            wb(1'b1, `ADR_CFG_SECOND, r[7:0]);
            wb(1'b1, `ADR_VAL_A, 8'h00);
            wb(1'b1, 3'h3, 8'h04);
            wb(1'b1, `ADR_RUN, 8'h02);
            tick(4'h3, 3);
            check("wide pwm", portBPins[0], r == 0);
        end
        doReset("wide pwm");
        wb(1'b1, `ADR_CFG_FIRST, 8'h10);
        wb(1'b1, `ADR_CFG_SECOND, {SRC_1K, CAP_RISE, 4'h0});
        wb(1'b1, `ADR_RUN, 8'h01);
        tick(4'h1, 5);
        drive(4'h8);
        check("capture irq", irqCnt[0] - base[0], 1);
        wb(1'b0, `ADR_VAL_A, 8'h00);
        shadow = rd;
        check("shadow range", shadow >= 5 && shadow <= 8, 1);
        tick(4'h1, 2);
        wb(1'b0, `ADR_VAL_A, 8'h00);
        check("shadow held", rd, shadow);
        drive(4'h0);
        foreach (capRow[i])
        begin
            wb(1'b1, `ADR_RUN, 8'h00);
            wb(1'b1, `ADR_CFG_SECOND, {capRow[i], capEdg[i], 4'h0});
            wb(1'b1, `ADR_RUN, 8'h01);
            base = irqCnt;
            drive(4'hF & ~(4'h1 << capRow[i]));
            drive(4'hF);
            drive(4'h1 << capRow[i]);
            drive(4'h0);
            hi = capEdg[i] == 2'h3 ? 2 : capEdg[i] == 2'h0 ? 0 : 1;
            check("capture edges", irqCnt[0] - base[0], hi);
        end
        // a pulse between two ticks is shorter than a counter period
        wb(1'b1, `ADR_CFG_SECOND, {SRC_1K, CAP_BOTH, 4'h0});
        base = irqCnt;
        @(posedge clk);
        prescaler1k <= 1'b1;
        @(posedge clk);
        prescaler1k <= 1'b0;
        tick(4'h1, 3);
        check("short pulse", irqCnt[0] - base[0], 0);
        $display("test capture done, mismatches %0d", fails);
        give_verdict();
    end
endmodule
`default_nettype wire
